// ### src/i2c_input_output_expander.sv
// port expander: two-wire slave, eight outputs, eight watched inputs, apb side registers
`timescale 1ns/10ps
`include "expander_map.svh"
module i2c_input_output_expander (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        scl,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        reset_pin_n,
	input  wire logic        addr_select_low_pin,
	input  wire logic        addr_select_high_pin,
	input  wire logic [7:0]  input_pins,
	output logic      [7:0]  output_pins,
	output logic             int_n_out,
	output logic             int_n_oe
);
	import expander_pkg::*;

	localparam state_s S_RST = '{
		st:        ST_IDLE,
		cnt:       4'h0,
		sh:        8'h00,
		tx:        8'h00,
		rw:        1'b0,
		tgt_in:    1'b0,
		ack_ok:    1'b0,
		byte_sel:  1'b0,
		sda_oe:    1'b0,
		scl_q:     1'b1,
		sda_q:     1'b1,
		ne_scl:    2'h3,
		ne_sda:    2'h3,
		outp:      `OUT_DEF_RST,
		mask:      `MASK_RST,
		out_def:   `OUT_DEF_RST,
		in_prev:   8'h00,
		warm:      2'h0,
		flags:     8'h00,
		flag_snap: 8'h00,
		int_act:   1'b0,
		ev_stat:   3'h0,
		ev_en:     `EVT_EN_RST,
		prdata:    32'h0000_0000
	};

	state_s             s_reg;
	state_s             s_next;
	logic [`SYNC_W-1:0] sy;
	logic               scl_s;
	logic               sda_s;
	logic               rstp_s;
	logic [1:0]         ad_s;
	logic [7:0]         in_s;
	logic               scl_rise;
	logic               scl_fall;
	logic               start_c;
	logic               stop_c;
	logic [7:0]         chg_ev;
	logic [1:0]         cls_lo;
	logic [1:0]         cls_hi;
	logic [3:0]         lo_bits;
	logic [6:0]         addr_out;
	logic [6:0]         addr_in;
	logic [7:0]         rd_byte;
	logic               acc_clr;
	logic [2:0]         ev;
	logic [2:0]         ev_clr;
	logic               apb_setup;
	logic               apb_wr;
	logic               mapped;

	// a pin may be strapped to scl or sda as well as to a level
	function automatic logic [1:0] pin_class(input logic ne_c, input logic ne_d, input logic lvl);
		if (!ne_c) begin
			return `CLS_SCL;
		end else if (!ne_d) begin
			return `CLS_SDA;
		end
		return {1'b0, lvl};
	endfunction

	// every pin crosses into pclk through two flops first
	expander_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({input_pins, addr_select_high_pin, addr_select_low_pin, reset_pin_n, sda_in, scl}),
		.q       (sy)
	);

	assign scl_s  = sy[0];
	assign sda_s  = sy[1];
	assign rstp_s = sy[2];
	assign ad_s   = sy[4:3];
	assign in_s   = sy[12:5];

	// 100 MHz sampling gives over a hundred samples per phase of a 400 kHz bus clock
	assign scl_rise = scl_s && !s_reg.scl_q;
	assign scl_fall = !scl_s && s_reg.scl_q;
	assign start_c  = scl_s && s_reg.scl_q && s_reg.sda_q && !sda_s;
	assign stop_c   = scl_s && s_reg.scl_q && !s_reg.sda_q && sda_s;

	// change vector stays quiet until the synchroniser and history hold real samples
	assign chg_ev = (s_reg.warm == `WARM_DONE) ? (in_s ^ s_reg.in_prev) : 8'h00;

	// strap decoding; before the first transfer a strap to scl or sda reads as a level
	assign cls_lo   = pin_class(s_reg.ne_scl[0], s_reg.ne_sda[0], ad_s[0]);
	assign cls_hi   = pin_class(s_reg.ne_scl[1], s_reg.ne_sda[1], ad_s[1]);
	assign lo_bits  = {~cls_hi[1], cls_hi[0], cls_lo};
	assign addr_out = {`ADDR_OUT_GRP, lo_bits};
	assign addr_in  = {`ADDR_IN_GRP, lo_bits};

	// input reads alternate live levels and the flags captured at the address ack
	assign rd_byte = s_reg.tgt_in ? (s_reg.byte_sel ? s_reg.flag_snap : in_s) : s_reg.outp;

	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign mapped    = (paddr == `OFS_IRQ_MASK) || (paddr == `OFS_OUT_DEF) || (paddr == `OFS_PORT) ||
	                   (paddr == `OFS_EVT_STAT) || (paddr == `OFS_EVT_CLR) || (paddr == `OFS_EVT_EN);

	always_comb begin
		s_next = s_reg;
		acc_clr = 1'b0;
		ev = 3'h0;
		ev_clr = 3'h0;
		s_next.scl_q = scl_s;
		s_next.sda_q = sda_s;
		s_next.in_prev = in_s;
		if (s_reg.warm != `WARM_DONE) begin
			s_next.warm = s_reg.warm + 2'h1;
		end
		// strap evidence collects over each transfer; a start begins a fresh look
		for (int i = 0; i < 2; i++) begin
			s_next.ne_scl[i] = s_reg.ne_scl[i] | (ad_s[i] ^ scl_s);
			s_next.ne_sda[i] = s_reg.ne_sda[i] | (ad_s[i] ^ sda_s);
		end
		if (rstp_s) begin
			case (s_reg.st)
				ST_ADDR: begin
					if (scl_rise) begin
						s_next.sh = {s_reg.sh[6:0], sda_s};
						s_next.cnt = s_reg.cnt + 4'h1;
					end else if (scl_fall && s_reg.cnt == `BITS_DONE) begin
						if (s_reg.sh[7:1] == addr_out || s_reg.sh[7:1] == addr_in) begin
							s_next.tgt_in = (s_reg.sh[7:1] == addr_in);
							s_next.rw = s_reg.sh[0];
							s_next.sda_oe = 1'b1;
							s_next.st = ST_ACK;
							s_next.byte_sel = 1'b0;
							s_next.flag_snap = s_reg.flags;
							acc_clr = 1'b1;
						end else begin
							s_next.st = ST_IDLE;
						end
					end
				end
				ST_WDATA: begin
					if (scl_rise) begin
						s_next.sh = {s_reg.sh[6:0], sda_s};
						s_next.cnt = s_reg.cnt + 4'h1;
					end else if (scl_fall && s_reg.cnt == `BITS_DONE) begin
						s_next.sda_oe = 1'b1;
						s_next.st = ST_ACK;
						if (s_reg.tgt_in) begin
							s_next.mask = s_reg.sh;
						end else begin
							s_next.outp = s_reg.sh;
							ev[`EV_OUT_WR] = 1'b1;
						end
					end
				end
				ST_ACK, ST_RACK: begin
					if (scl_rise) begin
						s_next.ack_ok = !sda_s;
					end else if (scl_fall) begin
						s_next.cnt = 4'h0;
						if (s_reg.st == ST_RACK && !s_reg.ack_ok) begin
							s_next.st = ST_IDLE;
							s_next.sda_oe = 1'b0;
						end else if (s_reg.rw) begin
							s_next.tx = rd_byte;
							s_next.sda_oe = !rd_byte[7];
							s_next.byte_sel = !s_reg.byte_sel;
							s_next.st = ST_RDATA;
							ev[`EV_IN_RD] = s_reg.tgt_in;
						end else begin
							s_next.sda_oe = 1'b0;
							s_next.st = ST_WDATA;
						end
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						s_next.cnt = s_reg.cnt + 4'h1;
					end else if (scl_fall) begin
						if (s_reg.cnt == `BITS_DONE) begin
							s_next.sda_oe = 1'b0;
							s_next.st = ST_RACK;
						end else begin
							s_next.tx = {s_reg.tx[6:0], 1'b0};
							s_next.sda_oe = !s_reg.tx[6];
						end
					end
				end
				default: begin
					s_next.st = ST_IDLE;
				end
			endcase
			if (start_c) begin
				s_next.st = ST_ADDR;
				s_next.cnt = 4'h0;
				s_next.sda_oe = 1'b0;
				s_next.ne_scl = 2'h0;
				s_next.ne_sda = 2'h0;
			end else if (stop_c) begin
				s_next.st = ST_IDLE;
				s_next.sda_oe = 1'b0;
			end
		end else begin
			// pin reset voids the transfer but keeps flags and interrupt
			s_next.st = ST_IDLE;
			s_next.cnt = 4'h0;
			s_next.sda_oe = 1'b0;
		end

		// a change in the clearing cycle survives: set wins over clear
		s_next.flags = (acc_clr ? 8'h00 : s_reg.flags) | chg_ev;
		s_next.int_act = (acc_clr ? 1'b0 : s_reg.int_act) | (|(chg_ev & s_reg.mask));
		ev[`EV_CHG] = |chg_ev;

		if (apb_setup && !pwrite) begin
			if (paddr == `OFS_IRQ_MASK) begin
				s_next.prdata = {24'h00_0000, s_reg.mask};
			end else if (paddr == `OFS_OUT_DEF) begin
				s_next.prdata = {24'h00_0000, s_reg.out_def};
			end else if (paddr == `OFS_PORT) begin
				s_next.prdata = {8'h00, s_reg.flags, s_reg.outp, in_s};
			end else if (paddr == `OFS_EVT_STAT) begin
				s_next.prdata = {29'h0000_0000, s_reg.ev_stat};
			end else if (paddr == `OFS_EVT_EN) begin
				s_next.prdata = {29'h0000_0000, s_reg.ev_en};
			end else begin
				s_next.prdata = 32'h0000_0000;
			end
		end
		if (apb_wr) begin
			if (paddr == `OFS_IRQ_MASK) begin
				s_next.mask = pwdata[7:0];
			end else if (paddr == `OFS_OUT_DEF) begin
				s_next.out_def = pwdata[7:0];
				s_next.outp = pwdata[7:0];
			end else if (paddr == `OFS_EVT_CLR) begin
				ev_clr = pwdata[2:0];
			end else if (paddr == `OFS_EVT_EN) begin
				s_next.ev_en = pwdata[2:0];
			end
		end
		s_next.ev_stat = (s_reg.ev_stat & ~ev_clr) | ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= S_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata      = s_reg.prdata;
	assign pready      = 1'b1;
	assign pslverr     = psel && penable && !mapped;
	assign irq         = |(s_reg.ev_stat & s_reg.ev_en);
	assign sda_out     = 1'b0;
	assign sda_oe      = s_reg.sda_oe;
	assign output_pins = s_reg.outp;
	assign int_n_out   = 1'b0;
	assign int_n_oe    = s_reg.int_act;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_addr_out;
		(rstp_s && !start_c && !stop_c && s_reg.st == ST_ADDR && scl_fall && s_reg.cnt == `BITS_DONE &&
		 s_reg.sh[7:1] == addr_out) |=> (s_reg.st == ST_ACK && sda_oe && !s_reg.tgt_in);
	endproperty
	a_addr_out: assert property (p_addr_out) else $error("output address not acknowledged");

	property p_rst_pin;
		!rstp_s |=> (s_reg.st == ST_IDLE && !sda_oe);
	endproperty
	a_rst_pin: assert property (p_rst_pin) else $error("reset pin left the bus engine busy");

	property p_flag_set;
		(chg_ev != 8'h00) |=> ((s_reg.flags & $past(chg_ev)) == $past(chg_ev));
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("input change did not set its flag");

	property p_flag_sticky;
		!acc_clr |=> ((s_reg.flags & $past(s_reg.flags)) == $past(s_reg.flags));
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("change flag dropped without access");

	property p_flag_clear;
		(acc_clr && chg_ev == 8'h00) |=> (s_reg.flags == 8'h00 && !int_n_oe);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("bus access did not clear flags");

	property p_mask_off;
		(!int_n_oe && (chg_ev & s_reg.mask) == 8'h00) |=> !int_n_oe;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("masked change raised the interrupt");

	property p_int_set;
		((chg_ev & s_reg.mask) != 8'h00) |=> int_n_oe ##1 (int_n_oe || $past(acc_clr));
	endproperty
	a_int_set: assert property (p_int_set) else $error("enabled change did not pull interrupt low");

	property p_rst_keeps_int;
		(!rstp_s && chg_ev == 8'h00) |=> $stable(int_n_oe) && $stable(s_reg.flags);
	endproperty
	a_rst_keeps_int: assert property (p_rst_keeps_int) else $error("reset pin disturbed the interrupt");

	property p_out_write;
		(rstp_s && !start_c && !stop_c && s_reg.st == ST_WDATA && scl_fall && s_reg.cnt == `BITS_DONE &&
		 !s_reg.tgt_in && !(apb_wr && paddr == `OFS_OUT_DEF)) |=> (output_pins == $past(s_reg.sh));
	endproperty
	a_out_write: assert property (p_out_write) else $error("written byte did not reach outputs");

	c_out_write: cover property (s_reg.st == ST_WDATA && scl_fall && s_reg.cnt == `BITS_DONE && !s_reg.tgt_in);
	c_in_read: cover property (s_reg.st == ST_RDATA && s_reg.tgt_in && scl_fall && s_reg.cnt == `BITS_DONE);
	c_int: cover property (!int_n_oe ##1 int_n_oe);
	c_rst_pin: cover property (s_reg.st != ST_IDLE ##1 !rstp_s);
endmodule

// ### src/expander_map.svh
// constants of the two-wire port expander and its register map
// Function
// - the device answers at one slave address of the 101xxxx group for the outputs and one of 110xxxx for the inputs.
// - the low four address bits come from how the two address-select pins are tied, giving two of 32 addresses.
// - the serial link works with a master-supplied bus clock of up to 400 kHz, which the master must not exceed.
// - the reset pin clears the serial state machine and abandons any transaction in progress.
// - eight push-pull output bits and eight input bits are separate ports.
// - every input is sampled continuously, whatever the bus is doing.
// - a level change on an input sets that input's own bit in an 8-bit change-flag vector.
// - a change flag stays set until the ports are next accessed, even if the input returns.
// - all change flags clear when a later bus read or write addresses the device.
// - an 8-bit mask selects which inputs may assert the interrupt; unselected changes do not.
// - the default level of the eight outputs is selectable, not fixed.
// - after power-up the interrupt mask is all ones.
// - with the default mask any input change pulls the interrupt low until the next bus access.
// - the reset pin leaves the interrupt output and its latched state untouched.
// - power-up clears all change flags and releases the interrupt output.
`ifndef EXPANDER_MAP_SVH
`define EXPANDER_MAP_SVH

`define OFS_IRQ_MASK 8'h00
`define OFS_OUT_DEF  8'h04
`define OFS_PORT     8'h08
`define OFS_EVT_STAT 8'h0C
`define OFS_EVT_CLR  8'h10
`define OFS_EVT_EN   8'h14

`define MASK_RST     8'hFF
`define OUT_DEF_RST  8'h00
`define EVT_EN_RST   3'h0

`define EV_CHG       0
`define EV_OUT_WR    1
`define EV_IN_RD     2

`define ADDR_OUT_GRP 3'h5
`define ADDR_IN_GRP  3'h6
`define CLS_SCL      2'h2
`define CLS_SDA      2'h3
`define BITS_DONE    4'h8
`define WARM_DONE    2'h3
`define SYNC_W       13

`endif

// ### src/expander_pkg.sv
// types shared by the port expander modules
`include "expander_map.svh"
package expander_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_ACK   = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_RACK  = 3'b101
	} bus_st_e;

	typedef struct packed {
		logic [`SYNC_W-1:0] s1;
		logic [`SYNC_W-1:0] s2;
	} sync_s;

	typedef struct packed {
		bus_st_e     st;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  tx;
		logic        rw;
		logic        tgt_in;
		logic        ack_ok;
		logic        byte_sel;
		logic        sda_oe;
		logic        scl_q;
		logic        sda_q;
		logic [1:0]  ne_scl;
		logic [1:0]  ne_sda;
		logic [7:0]  outp;
		logic [7:0]  mask;
		logic [7:0]  out_def;
		logic [7:0]  in_prev;
		logic [1:0]  warm;
		logic [7:0]  flags;
		logic [7:0]  flag_snap;
		logic        int_act;
		logic [2:0]  ev_stat;
		logic [2:0]  ev_en;
		logic [31:0] prdata;
	} state_s;
endpackage

// ### src/expander_sync.sv
// two-stage synchroniser for all pins that enter the pclk domain
`timescale 1ns/10ps
`include "expander_map.svh"
module expander_sync (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic [`SYNC_W-1:0]    d,
	output logic      [`SYNC_W-1:0]    q
);
	import expander_pkg::*;

	sync_s s_reg;
	sync_s s_next;

	always_comb begin
		s_next = s_reg;
		s_next.s1 = d;
		s_next.s2 = s_reg.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.s2;
endmodule

// ### testbench/i2c_master_model.sv
// behavioural two-wire bus master with a 125 ns bit period
`timescale 1ns/10ps
module i2c_master_model (
	output logic      scl,
	output logic      sda_lo,
	input  wire logic sda
);
	localparam real Q = 31.25;

	initial begin
		scl = 1'b1;
		sda_lo = 1'b0;
	end

	task automatic start();
		sda_lo = 1'b1;  // sda falls while scl is high
		#(2*Q);
		scl = 1'b0;
	endtask

	// data moves only while scl is low, so no false start or stop is seen
	task automatic bit_io(input logic b, output logic r);
		#Q sda_lo = ~b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
	endtask

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);  // msb first
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bit_io(1'b1, r);
			d = {d[6:0], r};
		end
		bit_io(nack, r);
	endtask

	// clock stands still high after the stop
	task automatic stop();
		#Q sda_lo = 1'b1;
		#Q scl = 1'b1;
		#(2*Q) sda_lo = 1'b0;
		#(4*Q);
	endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the port expander
`timescale 1ns/10ps
`include "expander_map.svh"
module testbench;
	localparam logic [6:0] OUT_A = 7'h59;
	localparam logic [6:0] IN_A  = 7'h69;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sda_out, sda_oe;
	logic        int_n_out, int_n_oe, scl, sda_lo, reset_pin_n, ad_lo, ad_hi, err, ka, kd, strap;
	logic [7:0]  paddr, input_pins, output_pins, b, b2;
	logic [31:0] pwdata, prdata, rd;
	wire         sda;
	int          errors, n_tests;

	// pull-up: the wire is high whenever nobody pulls it low
	assign sda = ((sda_oe & ~sda_out) | sda_lo) ? 1'b0 : 1'b1;

	i2c_input_output_expander dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.reset_pin_n(reset_pin_n), .addr_select_low_pin(ad_lo), .addr_select_high_pin(strap ? sda : ad_hi),
		.input_pins(input_pins), .output_pins(output_pins), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
	i2c_master_model mdl (.scl(scl), .sda_lo(sda_lo), .sda(sda));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			$display("mismatch %0t %s", $time, m);
			errors++;
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic xw(input logic [6:0] a, input logic [7:0] d);
		mdl.start();
		mdl.wr_byte({a, 1'b0}, ka);
		kd = 1'b0;
		if (ka) mdl.wr_byte(d, kd);
		mdl.stop();
		repeat (10) @(posedge pclk);
	endtask

	task automatic setin(input logic [7:0] v);
		@(posedge pclk);
		input_pins <= v;
		repeat (8) @(posedge pclk);
	endtask

	task automatic t_reset_vals();
		apb(1'b0, `OFS_IRQ_MASK, 32'h0);
		chk(rd, 32'h0000_00FF, "mask reset");
		apb(1'b0, `OFS_PORT, 32'h0);
		chk(rd, 32'h0, "flags reset");
		chk(int_n_oe, 1'b0, "int reset");
		chk({int_n_out, sda_out, pready}, 3'b001, "pin levels");
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1'b1, "unmapped");
	endtask

	task automatic t_out_write();
		xw(OUT_A, 8'hA5);
		chk({ka, kd}, 2'b11, "out acks");
		chk(output_pins, 8'hA5, "out byte");
		xw(7'h5A, 8'h00);
		chk(ka, 1'b0, "foreign addr");
		// high strap wired to the data line turns the low address bits into 0101
		strap <= 1'b1;
		xw(7'h55, 8'hA5);
		strap <= 1'b0;
		chk({ka, kd, output_pins}, 10'h3A5, "data line strap");
	endtask

	task automatic t_change();
		setin(8'h08);
		setin(8'h00);
		chk(irq, 1'b0, "irq disabled");
		apb(1'b1, `OFS_EVT_EN, 32'h1);
		chk(irq, 1'b1, "irq on");
		apb(1'b0, `OFS_EVT_EN, 32'h0);
		chk(rd, 32'h1, "event enable");
		apb(1'b0, `OFS_PORT, 32'h0);
		chk(rd[23:16], 8'h08, "transient flag");
		chk(int_n_oe, 1'b1, "int on");
		apb(1'b1, `OFS_EVT_CLR, 32'h7);
		chk(irq, 1'b0, "irq cleared");
	endtask

	task automatic t_reset_pin();
		// scl parks low while the device drives bit 7 of a read, so the reset meets a busy engine
		mdl.start();
		mdl.wr_byte({IN_A, 1'b1}, ka);
		setin(8'h10);
		chk({ka, sda_oe}, 2'b11, "engine driving");
		reset_pin_n <= 1'b0;
		repeat (60) @(posedge pclk);
		chk(sda_oe, 1'b0, "engine idle");
		chk(int_n_oe, 1'b1, "int kept");
		reset_pin_n <= 1'b1;
		repeat (110) @(posedge pclk);
		mdl.stop();
		chk(output_pins, 8'hA5, "outputs kept");
		xw(OUT_A, 8'h3C);
		chk({ka, kd, output_pins}, 10'h33C, "after reset pin");
	endtask

	task automatic t_read_in();
		apb(1'b1, `OFS_EVT_CLR, 32'h7);
		setin(8'h5A);
		mdl.start();
		mdl.wr_byte({IN_A, 1'b1}, ka);
		mdl.rd_byte(1'b0, b);
		mdl.rd_byte(1'b1, b2);
		mdl.stop();
		repeat (10) @(posedge pclk);
		chk({ka, b}, 9'h15A, "input read");
		chk(b2, 8'h4A, "flag byte");
		chk(int_n_oe, 1'b0, "int cleared");
		apb(1'b0, `OFS_PORT, 32'h0);
		chk(rd[23:16], 8'h00, "flags cleared");
		apb(1'b0, `OFS_EVT_STAT, 32'h0);
		chk(rd, 32'h5, "event status");
	endtask

	task automatic t_mask();
		xw(IN_A, 8'h01);
		apb(1'b0, `OFS_IRQ_MASK, 32'h0);
		chk(rd, 32'h1, "mask write");
		setin(8'h52);
		chk(int_n_oe, 1'b0, "masked change");
		setin(8'h53);
		chk(int_n_oe, 1'b1, "unmasked change");
	endtask

	task automatic t_out_def();
		apb(1'b1, `OFS_OUT_DEF, 32'hC3);
		chk(output_pins, 8'hC3, "default level");
		mdl.start();
		mdl.wr_byte({OUT_A, 1'b1}, ka);
		mdl.rd_byte(1'b1, b);
		mdl.stop();
		chk({ka, b}, 9'h1C3, "output read back");
	endtask

	task automatic tally_and_finish();
		if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#400000;
		errors++;
		tally_and_finish();
	end

	initial begin
		errors = 0;
		n_tests = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		reset_pin_n = 1'b1;
		ad_lo = 1'b1;
		ad_hi = 1'b0;
		strap = 1'b0;
		input_pins = 8'h00;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		t_reset_vals();
		t_out_write();
		t_change();
		t_reset_pin();
		t_read_in();
		t_mask();
		t_out_def();
		tally_and_finish();
	end
endmodule
